//--- core/uft_transmitter.sv
`timescale 1ns/10ps
// Contract
// - one start, five to nine data, none/even/odd parity, one/two stops
// - start bit first, then data least significant bit first
// - parity bit follows last data bit, precedes first stop
// - next frame follows back to back, else line idles high
// - start bit low, stop bits high, idle line high
// - one frame-format setting shared by transmitter and receiver
// - size field picks data bits; parity field enables, picks odd/even
// - stop select picks one or two; receiver checks first stop only
// - even parity is xor of data; odd is its inverse
// - enabled transmitter owns the data pin
// - synchronous master-mode enabled transmitter owns the transfer clock pin
// - data register write loads buffer and starts transmission
// - buffer moves to shifter when idle or right after last stop
// - shifter sends one frame at divisor, double speed or pin rate
// - unused upper bits of short characters are ignored
// - buffer-empty flag set when empty, cleared by data write
// - complete flag sets at frame end with empty buffer; one clears
// - disable waits until shifter and buffer empty, then pin released
// - baud down-counter reloads at zero or low-byte write, ticks at zero
module uft_transmitter
  import uft_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // software side
  input wire logic serial_data_wr,
  input wire logic [7:0] serial_data_reg,
  input wire logic tx_ninth_bit,
  input wire logic transmitter_enable,
  input wire logic tx_complete_clear,
  input wire logic tx_complete_ack,
  // frame format
  input wire logic [2:0] char_size_field,
  input wire logic [1:0] parity_mode_field,
  input wire logic stop_bits_select,
  // clocking
  input wire logic [DIV_WIDTH-1:0] baud_divisor,
  input wire logic baud_divisor_low_wr,
  input wire logic double_speed_bit,
  input wire logic sync_mode,
  input wire logic xck_slave,
  input wire logic clock_polarity,
  // pins
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe,
  output logic txd_out,
  output logic txd_oe,
  // status
  output logic tx_buffer_empty_flag,
  output logic tx_complete_flag
);
  uft_tick_if tk ();
  logic xck_raw;
  uft_state_t st_q;
  logic [8:0] buf_q, sh_q;
  logic buf_full_q, own_q, par_q;
  logic [3:0] cnt_q;
  logic stop2_q;
  logic txd_q, xck_pin_q, xck_oe_q, txc_q, tx_buffer_empty_flag_q;

  uft_bit_clock u_clk (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .baud_divisor(baud_divisor[DIV_W-1:0]),
    .baud_divisor_low_wr(baud_divisor_low_wr),
    .double_speed_bit(double_speed_bit),
    .sync_mode(sync_mode),
    .xck_slave(xck_slave),
    .xck_idle_level(clock_polarity),
    .xck_in_pin(transfer_clock_pin_in),
    .xck_out(xck_raw),
    .tick(tk.gen)
  );

  wire [3:0] nbits = uft_nbits(char_size_field);
  wire par_en = parity_mode_field[PAR_EN_BIT];
  wire [8:0] mask = 9'h1ff >> (4'h9 - nbits);
  wire [8:0] load_val = {tx_ninth_bit, serial_data_reg} & mask;
  wire tick = tk.bit_tick;
  wire idle = (st_q == ST_IDLE);
  wire last_stop = (st_q == ST_STOP) && tick && !stop2_q;
  // shifter load points
  // idle loads wait for a tick so the start bit is a full period;
  // a disabled, unowned shifter first waits one cycle, until the full buffer sets own_q, then for that tick
  wire take = buf_full_q && (own_q || transmitter_enable) &&
              ((idle && tick) || last_stop);
  wire last_data = (cnt_q == nbits - 4'h1);
  wire frame_done = last_stop && !buf_full_q;
  wire own_d = transmitter_enable || !(idle && !buf_full_q);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      buf_q <= CHAR_RESET;
      buf_full_q <= 1'b0;
    end else if (clk_en) begin
      if (serial_data_wr) begin
        buf_q <= load_val;
        buf_full_q <= 1'b1;
      end else if (take) begin
        buf_full_q <= 1'b0;
      end
    end
  end

  // frame sequencer; format changes mid-frame are not guarded
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      sh_q <= CHAR_RESET;
      cnt_q <= CNT_RESET;
      par_q <= 1'b0;
      stop2_q <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        sh_q <= buf_q;
        par_q <= (^buf_q) ^ parity_mode_field[PAR_ODD_BIT];
        st_q <= ST_START;
        cnt_q <= CNT_RESET;
      end else if (tick) begin
        case (st_q)
          ST_START: st_q <= ST_DATA;
          ST_DATA: begin
            sh_q <= sh_q >> 1;
            cnt_q <= cnt_q + 4'h1;
            if (last_data) st_q <= par_en ? ST_PAR : ST_STOP;
            stop2_q <= stop_bits_select;
          end
          ST_PAR: st_q <= ST_STOP;
          ST_STOP: begin
            if (stop2_q) stop2_q <= 1'b0;
            else st_q <= ST_IDLE;
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  wire line_d = (st_q == ST_START) ? 1'b0 :
                (st_q == ST_DATA) ? sh_q[0] :
                (st_q == ST_PAR) ? par_q : 1'b1;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      own_q <= 1'b0;
      txd_q <= 1'b1;
      xck_pin_q <= 1'b0;
      xck_oe_q <= 1'b0;
      tx_buffer_empty_flag_q <= 1'b1;
      txc_q <= 1'b0;
    end else if (clk_en) begin
      own_q <= own_d;
      txd_q <= line_d;
      xck_pin_q <= xck_raw;
      xck_oe_q <= own_d && tk.sync_active && !xck_slave;
      tx_buffer_empty_flag_q <= !((buf_full_q && !take) || serial_data_wr);
      if (frame_done) txc_q <= 1'b1;
      else if (tx_complete_clear || tx_complete_ack) txc_q <= 1'b0;
    end
  end

  assign txd_oe = own_q;
  assign txd_out = txd_q;
  assign transfer_clock_pin_out = xck_pin_q;
  assign transfer_clock_pin_oe = xck_oe_q;
  assign tx_buffer_empty_flag = tx_buffer_empty_flag_q;
  assign tx_complete_flag = txc_q;
endmodule : uft_transmitter

//--- core/uft_pkg.sv
package uft_pkg;
  // character size field codes
  localparam logic [2:0] CSZ_5 = 3'h0;
  localparam logic [2:0] CSZ_6 = 3'h1;
  localparam logic [2:0] CSZ_7 = 3'h2;
  localparam logic [2:0] CSZ_8 = 3'h3;
  localparam logic [2:0] CSZ_9 = 3'h7;
  // parity mode field codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam int PAR_EN_BIT = 1;
  localparam int PAR_ODD_BIT = 0;
  // transmitter prescale of the baud tick
  localparam logic [3:0] PRE_NORMAL = 4'hf;
  localparam logic [3:0] PRE_DOUBLE = 4'h7;
  localparam logic [3:0] PRE_SYNC = 4'h1;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
  localparam logic [8:0] CHAR_RESET = 9'h000;
  localparam logic [3:0] CNT_RESET = 4'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_PAR = 5'b01000,
    ST_STOP = 5'b10000
  } uft_state_t;

  function automatic logic [3:0] uft_nbits(input logic [2:0] csz);
    case (csz)
      CSZ_5: uft_nbits = 4'h5;
      CSZ_6: uft_nbits = 4'h6;
      CSZ_7: uft_nbits = 4'h7;
      CSZ_9: uft_nbits = 4'h9;
      default: uft_nbits = 4'h8;
    endcase
  endfunction : uft_nbits
endpackage : uft_pkg

//--- core/uft_tick_if.sv
`timescale 1ns/10ps
interface uft_tick_if;
  logic bit_tick;
  logic sync_active;
  modport gen (output bit_tick, output sync_active);
  modport use_side (input bit_tick, input sync_active);
endinterface : uft_tick_if

//--- core/uft_bit_clock.sv
`timescale 1ns/10ps
module uft_bit_clock
  import uft_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // rate setup
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic baud_divisor_low_wr,
  input wire logic double_speed_bit,
  input wire logic sync_mode,
  input wire logic xck_slave,
  input wire logic xck_idle_level,
  input wire logic xck_in_pin,
  output logic xck_out,
  uft_tick_if.gen tick
);
  logic [DIV_W-1:0] cnt_q;
  logic [3:0] pre_q;
  logic xs1_q, xs2_q, xs3_q;
  logic xck_q;
  wire base_zero = (cnt_q == DIV_RESET);
  wire [3:0] pre_top = sync_mode ? PRE_SYNC :
                       (double_speed_bit ? PRE_DOUBLE : PRE_NORMAL);
  wire pre_wrap = base_zero && (pre_q >= pre_top);
  // slave mode: data changes on the chosen edge of the pin clock
  wire ext_edge = (xs2_q != xs3_q) && (xs2_q != xck_idle_level);
  wire slave = sync_mode && xck_slave;

  assign tick.bit_tick = slave ? ext_edge : pre_wrap;
  assign tick.sync_active = sync_mode;
  assign xck_out = xck_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q <= DIV_RESET;
      pre_q <= CNT_RESET;
      xs1_q <= 1'b0;
      xs2_q <= 1'b0;
      xs3_q <= 1'b0;
      xck_q <= 1'b0;
    end else if (clk_en) begin
      xs1_q <= xck_in_pin;
      xs2_q <= xs1_q;
      xs3_q <= xs2_q;
      if (base_zero || baud_divisor_low_wr) cnt_q <= baud_divisor;
      else cnt_q <= cnt_q - 1'b1;
      if (base_zero) pre_q <= pre_wrap ? CNT_RESET : pre_q + 1'b1;
      // master clock toggles twice per bit
      if (base_zero && sync_mode && !xck_slave) xck_q <= ~xck_q;
      else if (!sync_mode) xck_q <= xck_idle_level;
    end
  end
endmodule : uft_bit_clock

//--- sim/uft_transmitter_properties.sv
`timescale 1ns/10ps
module uft_transmitter_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // software side
  input wire logic clk_en,
  input wire logic serial_data_wr,
  input wire logic transmitter_enable,
  input wire logic tx_complete_clear,
  input wire logic tx_complete_ack,
  input wire logic sync_mode,
  // pins and flags
  input wire logic transfer_clock_pin_oe,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic tx_buffer_empty_flag,
  input wire logic tx_complete_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_write_clears_empty: assert property (
    serial_data_wr && clk_en |=> !tx_buffer_empty_flag) else $error("full");
  a_enable_owns_pin: assert property (
    $rose(transmitter_enable) |-> ##[1:2] txd_oe) else $error("no pin");
  a_released_idle: assert property (
    !txd_oe |-> txd_out) else $error("released line low");
  a_done_when_empty: assert property (
    $rose(tx_complete_flag) |-> tx_buffer_empty_flag && txd_out)
    else $error("complete too early");
  a_clear_needs_cause: assert property (
    $fell(tx_complete_flag) |-> $past(tx_complete_clear) ||
    $past(tx_complete_ack)) else $error("complete lost");
  a_write_starts_frame: assert property (
    serial_data_wr && tx_buffer_empty_flag && tx_complete_flag
    |-> ##[2:40] !txd_out) else $error("no start bit");
  a_release_when_done: assert property (
    $fell(txd_oe) |-> tx_buffer_empty_flag && txd_out)
    else $error("released busy");
  a_async_clock_free: assert property (
    !sync_mode |-> !transfer_clock_pin_oe) else $error("clock pin owned");
endmodule : uft_transmitter_properties

bind uft_transmitter uft_transmitter_properties chk_u (.*);

//--- sim/uft_rx_model.sv
`timescale 1ns/10ps
module uft_rx_model #(
  parameter int BIT = 16
) (
  // line and format
  input wire logic clk,
  input wire logic line,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  // last frame
  output logic [8:0] data,
  output logic par,
  output logic stop_ok,
  output int frames
);
  initial begin
    frames = 0;
    forever begin
      @(negedge line);
      repeat (BIT / 2) @(posedge clk);
      data = 9'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (BIT) @(posedge clk);
        data[i] = line;
      end
      if (par_en) begin
        repeat (BIT) @(posedge clk);
        par = line;
      end
      repeat (BIT) @(posedge clk);
      stop_ok = line;
      frames++;
    end
  end
endmodule : uft_rx_model

//--- sim/uft_transmitter_bench.sv
`timescale 1ns/10ps
module uft_transmitter_bench;
  import uft_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic serial_data_wr = 1'b0, tx_ninth_bit = 1'b0, stop_bits_select = 1'b0;
  logic transmitter_enable = 1'b0, tx_complete_clear = 1'b0;
  logic tx_complete_ack = 1'b0, baud_divisor_low_wr = 1'b0;
  logic double_speed_bit = 1'b1, sync_mode = 1'b0, xck_slave = 1'b0;
  logic clock_polarity = 1'b0, transfer_clock_pin_in = 1'b0;
  logic [7:0] serial_data_reg = 8'h00;
  logic [2:0] char_size_field = CSZ_8;
  logic [1:0] parity_mode_field = PAR_NONE;
  logic [11:0] baud_divisor = 12'h001;
  logic transfer_clock_pin_out, transfer_clock_pin_oe, txd_out, txd_oe;
  logic tx_buffer_empty_flag, tx_complete_flag, rpar, rstop, pe = 1'b0;
  logic [8:0] rdata;
  logic [3:0] nb = 4'h8;
  logic [2:0] cs [5] = '{CSZ_5, CSZ_6, CSZ_7, CSZ_8, CSZ_9};
  logic [1:0] pc [3] = '{PAR_NONE, PAR_EVEN, PAR_ODD};
  int frames;
  int n_mismatch = 0;
  int check_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  // link clock idles here; async frames ignore it
  always #24 transfer_clock_pin_in = sync_mode & ~transfer_clock_pin_in;
  uft_transmitter dut_u (.*);
  // bit period 8 x (divisor + 1) in double speed
  uft_rx_model #(.BIT(16)) rx_u (.clk(ref_clk), .line(txd_out), .nbits(nb),
    .par_en(pe), .data(rdata), .par(rpar), .stop_ok(rstop), .frames(frames));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic send(input logic [8:0] v, input logic [1:0] p);
    int f0;
    logic [8:0] m;
    f0 = frames;
    m = (9'h001 << nb) - 9'h001;
    for (int k = 0; k < 400 && tx_buffer_empty_flag !== 1'b1; k++) begin
      @(posedge ref_clk);
    end
    serial_data_wr <= 1'b1;
    tx_complete_clear <= 1'b1;
    serial_data_reg <= v[7:0];
    tx_ninth_bit <= v[8];
    @(posedge ref_clk);
    serial_data_wr <= 1'b0;
    tx_complete_clear <= 1'b0;
    for (int k = 0; k < 400 && frames == f0; k++) @(posedge ref_clk);
    chk(rdata, v & m);
    if (p[1]) chk({8'h00, rpar}, {8'h00, ^(v & m) ^ p[0]});
    chk({8'h00, rstop}, 9'h001);
    for (int k = 0; k < 100 && tx_complete_flag !== 1'b1; k++) begin
      @(posedge ref_clk);
    end
    chk({8'h00, tx_complete_flag}, 9'h001);
  endtask : send
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    transmitter_enable <= 1'b1;
    @(posedge ref_clk);
    chk({8'h00, tx_buffer_empty_flag}, 9'h001);
    for (int i = 0; i < 5; i++) begin
      for (int p = 0; p < 3; p++) begin
        for (int s = 0; s < 2; s++) begin
          // format changes only once idle
          char_size_field <= cs[i];
          parity_mode_field <= pc[p];
          stop_bits_select <= s[0];
          nb <= (i == 4) ? 4'h9 : 4'(i + 5);
          pe <= (p > 0);
          @(posedge ref_clk);
          send(9'h1a5 ^ 9'(i * 77 + p * 13 + s), pc[p]);
        end
      end
    end
    transmitter_enable <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({8'h00, txd_oe}, 9'h000);
    chk({8'h00, transfer_clock_pin_oe}, 9'h000);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    final_report();
  end
endmodule : uft_transmitter_bench
